// ### design/fault_blink_consts.vh
`ifndef FAULT_BLINK_CONSTS_VH
`define FAULT_BLINK_CONSTS_VH
// ==========================================
// timing
`define CLK_HZ 10000000
`define BURST_PERIOD_S 3
`define BURST_PERIOD_CYC (`CLK_HZ * `BURST_PERIOD_S)
// short enough that seven blinks leave a clear gap in each period
`define BLINK_ON_MS 150
`define BLINK_OFF_MS 150
`define BLINK_ON_CYC (`CLK_HZ / 1000 * `BLINK_ON_MS)
`define BLINK_OFF_CYC (`CLK_HZ / 1000 * `BLINK_OFF_MS)
// ==========================================
// fault codes, value is blink count
`define CODE_NONE 3'h0
`define CODE_OVER_CURRENT 3'h1
`define CODE_OVER_VOLTAGE 3'h2
`define CODE_UNDER_VOLTAGE 3'h3
`define CODE_POSITION 3'h7
// ==========================================
// supply threshold, in 0.1 V
`define OVER_VOLTAGE_LIMIT 10'h226
`endif

// ### design/fault_latch.v
`include "fault_blink_consts.vh"
module fault_latch (
    input wire clk,
    input wire rst_n,
    input wire over_current,
    input wire over_voltage,
    input wire under_voltage,
    input wire position_error,
    output reg [2:0] code_q
);
    // ==========================================
    // first fault wins; same-cycle ties by severity
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            code_q <= `CODE_NONE;
        else if (code_q == `CODE_NONE)
        begin
            if (over_current)
                code_q <= `CODE_OVER_CURRENT;
            else if (over_voltage)
                code_q <= `CODE_OVER_VOLTAGE;
            else if (under_voltage)
                code_q <= `CODE_UNDER_VOLTAGE;
            else if (position_error)
                code_q <= `CODE_POSITION;
        end
    end
endmodule

// ### design/fault_blink_indicator.v
`include "fault_blink_consts.vh"
// Behaviour
// R01: green lamp on after power-up
// R02: red lamp blinks while fault latched
// R03: blink count 1,2,3,7 per fault
// R04: burst repeats every 3 seconds
// R05: over-voltage above 55 V
// R06: fault held until power cycle
// R07: only first fault latched and shown
module fault_blink_indicator #(
    parameter PERIOD_CYC = `BURST_PERIOD_CYC,
    parameter ON_CYC = `BLINK_ON_CYC,
    parameter OFF_CYC = `BLINK_OFF_CYC
) (
    input wire clk,
    input wire rst_n,
    input wire over_current,
    input wire [9:0] supply_decivolts,
    input wire under_voltage,
    input wire position_error,
    output reg green_led_q,
    output reg red_led_q,
    output reg fault_q,
    output reg [2:0] fault_code_q
);
    // counters sized for the full burst period at the system clock
    localparam CNT_W = 25;
    localparam [CNT_W-1:0] CNT_ZERO = 25'h0;
    localparam [CNT_W-1:0] CNT_ONE = 25'h1;
    localparam [CNT_W-1:0] PERIOD_W = PERIOD_CYC[CNT_W-1:0];
    localparam [CNT_W-1:0] ON_W = ON_CYC[CNT_W-1:0];
    localparam [CNT_W-1:0] OFF_W = OFF_CYC[CNT_W-1:0];
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_ON = 2'h1;
    localparam [1:0] S_OFF = 2'h2;
    localparam [1:0] S_GAP = 2'h3;

    reg over_voltage_d;
    reg over_voltage_q;
    wire [2:0] code;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [CNT_W-1:0] period_q;
    reg [CNT_W-1:0] period_d;
    reg [CNT_W-1:0] step_q;
    reg [CNT_W-1:0] step_d;
    reg [2:0] left_q;
    reg [2:0] left_d;
    reg red_d;
    reg fault_d;
    reg [2:0] fault_code_d;

    // ==========================================
    // helpers
    // true in the last cycle of a count that starts at zero
    function last_cycle;
        input [CNT_W-1:0] count;
        input [CNT_W-1:0] length;
        begin
            last_cycle = (count == length - CNT_ONE);
        end
    endfunction

    function [CNT_W-1:0] count_up;
        input [CNT_W-1:0] count;
        begin
            count_up = count + CNT_ONE;
        end
    endfunction

    function has_fault;
        input [2:0] fault_code;
        begin
            has_fault = (fault_code != `CODE_NONE);
        end
    endfunction

    // ==========================================
    // detection
    // compare is registered, so over-voltage latches one cycle after the rest
    always @*
    begin
        over_voltage_d = (supply_decivolts > `OVER_VOLTAGE_LIMIT); // R05
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            over_voltage_q <= 1'b0;
        else
            over_voltage_q <= over_voltage_d;
    end

    // reset only from power-on, so latch clears on power cycle alone
    fault_latch u_latch (
        .clk(clk),
        .rst_n(rst_n),
        .over_current(over_current),
        .over_voltage(over_voltage_q),
        .under_voltage(under_voltage),
        .position_error(position_error),
        .code_q(code)
    ); // R06 R07

    // ==========================================
    // period counter
    // restarts with each burst, so the cadence never drifts
    always @*
    begin
        period_d = count_up(period_q); // R04
        if (state_q == S_IDLE || last_cycle(period_q, PERIOD_W))
            period_d = CNT_ZERO;
    end

    // ==========================================
    // blink sequencer
    // limitation: code * (ON_CYC + OFF_CYC) must stay below PERIOD_CYC
    always @*
    begin
        state_d = state_q;
        step_d = step_q;
        left_d = left_q;
        red_d = red_led_q;
        case (state_q)
            S_IDLE:
            begin
                red_d = 1'b0;
                step_d = CNT_ZERO;
                if (has_fault(code))
                begin
                    state_d = S_ON; // R02
                    left_d = code; // R03
                    red_d = 1'b1;
                end
            end
            S_ON:
            begin
                step_d = count_up(step_q);
                if (last_cycle(step_q, ON_W))
                begin
                    red_d = 1'b0;
                    step_d = CNT_ZERO;
                    left_d = left_q - 3'h1;
                    if (left_q == 3'h1)
                        state_d = S_GAP; // R03
                    else
                        state_d = S_OFF;
                end
            end
            S_OFF:
            begin
                step_d = count_up(step_q);
                if (last_cycle(step_q, OFF_W))
                begin
                    red_d = 1'b1;
                    step_d = CNT_ZERO;
                    state_d = S_ON;
                end
            end
            S_GAP:
            begin
                if (last_cycle(period_q, PERIOD_W))
                begin
                    red_d = 1'b1; // R04
                    left_d = code;
                    step_d = CNT_ZERO;
                    state_d = S_ON;
                end
            end
            default:
            begin
                state_d = S_IDLE;
                red_d = 1'b0;
            end
        endcase
    end

    // ==========================================
    // fault status
    // status follows the latch one cycle late, in step with the red lamp
    always @*
    begin
        fault_d = has_fault(code); // R02
        fault_code_d = code; // R03
    end

    // ==========================================
    // sequencer registers
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= S_IDLE;
            period_q <= CNT_ZERO;
            step_q <= CNT_ZERO;
            left_q <= 3'h0;
        end
        else
        begin
            state_q <= state_d;
            period_q <= period_d;
            step_q <= step_d;
            left_q <= left_d;
        end
    end

    // ==========================================
    // lamp and status outputs
    // every output is a flop, so the lamps never glitch on decode
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            green_led_q <= 1'b0;
            red_led_q <= 1'b0;
            fault_q <= 1'b0;
            fault_code_q <= `CODE_NONE;
        end
        else
        begin
            green_led_q <= 1'b1; // R01
            red_led_q <= red_d; // R02
            fault_q <= fault_d;
            fault_code_q <= fault_code_d;
        end
    end
endmodule

// ### verif/fbi_props.sv
module fbi_props (
    input wire clk,
    input wire rst_n,
    input wire over_current,
    input wire [9:0] supply_decivolts,
    input wire under_voltage,
    input wire position_error,
    input wire green_led_q,
    input wire red_led_q,
    input wire fault_q,
    input wire [2:0] fault_code_q
);
timeunit 1ns;
timeprecision 1ns;
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
AST_GREEN: assert property ($past(rst_n) |-> green_led_q) else $error("green off");
AST_DARK: assert property (!fault_q |-> !red_led_q) else $error("red without fault");
AST_START: assert property ($rose(fault_q) |-> red_led_q) else $error("no blink");
AST_HOLD: assert property (fault_q |=> fault_q && $stable(fault_code_q))
    else $error("fault lost");
AST_REACT: assert property (over_current && !fault_q |-> ##[1:2] fault_q)
    else $error("slow latch");
AST_OC: assert property ($rose(fault_q) && fault_code_q == 3'h1 |->
    $past(over_current, 2)) else $error("code 1 cause");
AST_OV: assert property ($rose(fault_q) && fault_code_q == 3'h2 |->
    $past(supply_decivolts, 3) > 10'h226) else $error("code 2 cause");
AST_UV: assert property ($rose(fault_q) && fault_code_q == 3'h3 |->
    $past(under_voltage, 2)) else $error("code 3 cause");
AST_PE: assert property ($rose(fault_q) && fault_code_q == 3'h7 |->
    $past(position_error, 2)) else $error("code 7 cause");
endmodule
bind fault_blink_indicator fbi_props fbi_props_inst (.clk(clk), .rst_n(rst_n),
    .over_current(over_current), .supply_decivolts(supply_decivolts),
    .under_voltage(under_voltage), .position_error(position_error),
    .green_led_q(green_led_q), .red_led_q(red_led_q), .fault_q(fault_q),
    .fault_code_q(fault_code_q));

// ### verif/tb.sv
module tb;
timeunit 1ns;
timeprecision 1ns;
logic clk = 0, rst_n = 0, oc = 0, uv = 0, pe = 0;
logic [9:0] sv = 10'h0C8;
wire g, r, f;
wire [2:0] c;
int miscompares = 0, samples_checked = 0;
fault_blink_indicator #(.PERIOD_CYC(200), .ON_CYC(5), .OFF_CYC(5)) fault_blink_indicator_inst (
    .clk(clk), .rst_n(rst_n), .over_current(oc), .supply_decivolts(sv),
    .under_voltage(uv), .position_error(pe), .green_led_q(g), .red_led_q(r),
    .fault_q(f), .fault_code_q(c));
initial forever #50 clk = ~clk;
task report_and_stop;
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
task chk(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
        miscompares++;
        $display("[ERR] %s expected %0d seen %0d", n, e, s);
    end
endtask
// power cycle with quiet inputs
task pwr;
    rst_n = 0; oc = 0; uv = 0; pe = 0; sv = 10'h0C8;
    repeat (5) @(posedge clk);
    #1 rst_n = 1;
    repeat (2) @(posedge clk);
    #1 chk("green", 1, g);
endtask
// waits for the latch, then counts blinks over two bursts
task burst(input logic [2:0] e);
    int k, n, t;
    logic p;
    k = 0; n = 0; t = 0; p = 0;
    while (f !== 1'b1 && k < 20)
    begin
        @(posedge clk);
        #1 k++;
    end
    // a latch that never comes ends the run here
    if (f !== 1'b1)
    begin
        chk("fault", 1, f);
        report_and_stop;
    end
    else
    begin
        chk("code", e, c);
        for (k = 0; k < 400; k++)
        begin
            if (r === 1'b1 && !p) n++;
            if (r === 1'b1 && !p && n == e + 1) t = k;
            p = r;
            @(posedge clk);
            #1;
        end
        chk("blinks", 2 * e, n);
        chk("period", 200, t);
    end
endtask
initial
begin
    pwr; oc = 1; burst(1);
    oc = 0; repeat (10) @(posedge clk);
    #1 chk("held", 1, c);
    pwr; sv = 10'h226; repeat (10) @(posedge clk);
    #1 chk("no fault at limit", 0, f);
    sv = 10'h227; burst(2);
    pwr; uv = 1; burst(3);
    oc = 1; repeat (5) @(posedge clk);
    #1 chk("first kept", 3, c);
    pwr; pe = 1; burst(7);
    pwr; uv = 1; pe = 1; burst(3);
    report_and_stop;
end
endmodule
